// [core/irq_ctrl_top.sv]
// Interrupt controller with 20 maskable channels and four-channel micro-DMA engine
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
module irq_ctrl_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [3:0] hprot,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [irq_pkg::NUM_CH-1:0] periph_req,
   input wire logic wdt_req,
   input wire logic nmi_pin,
   input wire logic vec_read,
   output irq_pkg::irq_req_s irq_out,
   output irq_pkg::irq_ack_s ack_out,
   output irq_pkg::dma_done_s done_out,
   output irq_pkg::mem_req_s mem_out,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   output logic dma_busy
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_WRITE = 2'b10,
      ST_FINISH = 2'b11
   } dma_state_e;

   logic [irq_pkg::NUM_CH-1:0] pend_r;
   logic [irq_pkg::NUM_CH-1:0] pend_nxt;
   logic [irq_pkg::NUM_CH-1:0][2:0] lvl_r;
   logic nmi_pend_r;
   logic nmi_pend_nxt;
   logic wdt_pend_r;
   logic wdt_pend_nxt;
   logic nmi_s1_r;
   logic nmi_s2_r;
   logic nmi_s3_r;
   logic nmi_lvl_r;
   logic nmi_rise;
   logic [irq_pkg::NUM_DMA-1:0][4:0] svec_r;
   logic [irq_pkg::NUM_DMA-1:0][31:0] src_r;
   logic [irq_pkg::NUM_DMA-1:0][31:0] dst_r;
   logic [irq_pkg::NUM_DMA-1:0][4:0] mode_r;
   logic [irq_pkg::NUM_DMA-1:0][15:0] cnt_r;

   logic a_valid_r;
   logic a_write_r;
   logic a_map_r;
   logic a_priv_r;
   logic [7:0] a_idx_r;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic wr_en;
   logic [31:0] rd_word;
   logic [7:0] prio_pair;
   logic is_prio;
   logic is_svec;
   logic is_param;

   logic win_valid;
   logic [4:0] win_idx;
   logic [2:0] win_level;
   logic [4:0] win_idx_r;
   logic ack_take;
   logic hit;
   logic [1:0] hit_chan;
   irq_pkg::irq_req_s irq_r;
   irq_pkg::irq_ack_s ack_r;
   irq_pkg::dma_done_s done_r;
   irq_pkg::mem_req_s mem_r;
   dma_state_e st_r;
   logic [1:0] ch_r;
   logic [15:0] data_r;
   logic [15:0] cnt_dec;
   logic busy_r;

   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign irq_out = irq_r;
   assign ack_out = ack_r;
   assign done_out = done_r;
   assign mem_out = mem_r;
   assign dma_busy = busy_r;

   // Bus slave: address phase capture
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         a_valid_r <= 1'b0;
         a_write_r <= 1'b0;
         a_map_r <= 1'b0;
         a_priv_r <= 1'b0;
         a_idx_r <= 8'h00;
      end
      else if (hready)
      begin
         a_valid_r <= hsel && htrans[1];
         a_write_r <= hwrite;
         a_map_r <= (haddr[31:irq_pkg::ADDR_IDX_MSB+1] == '0) &&
                    (hsize == irq_pkg::HSIZE_WORD);
         a_priv_r <= hprot[irq_pkg::HPROT_PRIV_BIT];
         a_idx_r <= haddr[irq_pkg::ADDR_IDX_MSB:irq_pkg::ADDR_IDX_LSB];
      end
   end

   // Reads take one wait state so a write just before is always seen
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout_r <= 1'b1;
         hrdata_r <= 32'h0000_0000;
      end
      else if (!hreadyout_r)
      begin
         hreadyout_r <= 1'b1;
         hrdata_r <= rd_word;
      end
      else if (hready && hsel && htrans[1] && !hwrite)
      begin
         hreadyout_r <= 1'b0;
      end
   end

   assign hresp = 1'b0;
   assign wr_en = a_valid_r && a_write_r && a_map_r;
   assign prio_pair = a_idx_r - irq_pkg::IDX_PRIO_FIRST;
   assign is_prio = (a_idx_r >= irq_pkg::IDX_PRIO_FIRST) && (prio_pair < irq_pkg::IDX_PRIO_COUNT);
   assign is_svec = a_idx_r[7:2] == irq_pkg::IDX_SVEC_FIRST[7:2];
   assign is_param = (a_idx_r[7:4] == irq_pkg::IDX_PARAM_FIRST[7:4]) && a_priv_r;

   always_comb
   begin
      int ch;
      ch = 2 * int'(prio_pair);
      rd_word = 32'h0000_0000;
      if (a_map_r && is_prio)
      begin
         rd_word[3:0] = {pend_r[ch], lvl_r[ch]};
         rd_word[7:4] = {pend_r[ch+1], lvl_r[ch+1]};
      end
      else if (a_map_r && is_param)
      begin
         unique case (a_idx_r[3:2])
            irq_pkg::GRP_SRC: rd_word = src_r[a_idx_r[1:0]];
            irq_pkg::GRP_DST: rd_word = dst_r[a_idx_r[1:0]];
            irq_pkg::GRP_MODE: rd_word = {27'h0, mode_r[a_idx_r[1:0]]};
            irq_pkg::GRP_CNT: rd_word = {16'h0, cnt_r[a_idx_r[1:0]]};
         endcase
      end
   end

   // Non-maskable pin: three stages, a change counts once stages two and three agree
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         nmi_s1_r <= 1'b0;
         nmi_s2_r <= 1'b0;
         nmi_s3_r <= 1'b0;
         nmi_lvl_r <= 1'b0;
      end
      else
      begin
         nmi_s1_r <= nmi_pin;
         nmi_s2_r <= nmi_s1_r;
         nmi_s3_r <= nmi_s2_r;
         if (nmi_s2_r == nmi_s3_r)
         begin
            nmi_lvl_r <= nmi_s3_r;
         end
      end
   end

   assign nmi_rise = (nmi_s2_r == nmi_s3_r) && nmi_s3_r && !nmi_lvl_r;

   // A vector read is taken only while the engine is idle and a request stands
   assign ack_take = vec_read && irq_r.valid && (st_r == ST_IDLE);

   // Request flops: a new request wins over any clear in the same cycle
   always_comb
   begin
      logic clr;
      int ch;
      clr = 1'b0;
      ch = 2 * int'(prio_pair);
      for (int i = 0; i < irq_pkg::NUM_CH; i++)
      begin
         clr = ack_take && (int'(win_idx_r) == i + irq_pkg::NUM_NMI);
         if (wr_en && is_prio && (i == ch) && !hwdata[irq_pkg::PRIO_CLR_BIT])
         begin
            clr = 1'b1;
         end
         if (wr_en && is_prio && (i == ch + 1) &&
             !hwdata[irq_pkg::PRIO_HALF_W + irq_pkg::PRIO_CLR_BIT])
         begin
            clr = 1'b1;
         end
         pend_nxt[i] = periph_req[i] || (pend_r[i] && !clr);
      end
      nmi_pend_nxt = nmi_rise || (nmi_pend_r && !(ack_take && win_idx_r == 5'h00));
      wdt_pend_nxt = wdt_req || (wdt_pend_r && !(ack_take && win_idx_r == 5'h01));
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pend_r <= '0;
         nmi_pend_r <= 1'b0;
         wdt_pend_r <= 1'b0;
      end
      else
      begin
         pend_r <= pend_nxt;
         nmi_pend_r <= nmi_pend_nxt;
         wdt_pend_r <= wdt_pend_nxt;
      end
   end

   // Priority levels, two channels per register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         lvl_r <= {irq_pkg::NUM_CH{irq_pkg::RST_LEVEL}};
      end
      else if (wr_en && is_prio)
      begin
         lvl_r[2*prio_pair] <= hwdata[irq_pkg::PRIO_LVL_LSB +: 3];
         lvl_r[2*prio_pair+1] <= hwdata[irq_pkg::PRIO_HALF_W + irq_pkg::PRIO_LVL_LSB +: 3];
      end
   end

   // Start vectors: no privilege check, and they read back as zero
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         svec_r <= {irq_pkg::NUM_DMA{irq_pkg::RST_SVEC}};
      end
      else if (wr_en && is_svec)
      begin
         svec_r[a_idx_r[1:0]] <= hwdata[4:0];
      end
   end

   pend_arbiter u_arb (
      .pend({pend_nxt, wdt_pend_nxt, nmi_pend_nxt}),
      .lvl({lvl_r, irq_pkg::LEVEL_NMI, irq_pkg::LEVEL_NMI}),
      .win_valid(win_valid),
      .win_idx(win_idx),
      .win_level(win_level)
   );

   vec_match u_match (
      .field(irq_r.vector[8:4]),
      .svec(svec_r),
      .hit(hit),
      .chan(hit_chan)
   );

   // Presented request; held low while a transfer runs since the CPU is busy with it
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_r <= '0;
         win_idx_r <= 5'h00;
      end
      else
      begin
         irq_r.valid <= win_valid && !(ack_take && hit) &&
                        ((st_r == ST_IDLE) || (st_r == ST_FINISH));
         irq_r.level <= win_level;
         irq_r.vector <= {7'h00, irq_pkg::SRC_VEC[win_idx], 4'h0};
         win_idx_r <= win_idx;
      end
   end

   // Acceptance answer
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ack_r <= '0;
      end
      else
      begin
         ack_r.valid <= ack_take;
         if (ack_take)
         begin
            ack_r.dma <= hit;
            ack_r.chan <= hit_chan;
            ack_r.vector <= irq_r.vector;
         end
      end
   end

   assign cnt_dec = cnt_r[ch_r] - 16'h0001;

   // Micro-DMA sequencer
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_r <= ST_IDLE;
         ch_r <= 2'h0;
         busy_r <= 1'b0;
      end
      else
      begin
         unique case (st_r)
            ST_IDLE:
            begin
               if (ack_take && hit)
               begin
                  st_r <= ST_READ;
                  ch_r <= hit_chan;
                  busy_r <= 1'b1;
               end
            end
            ST_READ:
            begin
               if (mem_ack)
               begin
                  st_r <= ST_WRITE;
               end
            end
            ST_WRITE:
            begin
               if (mem_ack)
               begin
                  st_r <= ST_FINISH;
               end
            end
            ST_FINISH:
            begin
               st_r <= ST_IDLE;
               busy_r <= 1'b0;
            end
         endcase
      end
   end

   // Memory port; the request holds until acknowledged
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mem_r <= '0;
         data_r <= 16'h0000;
      end
      else
      begin
         mem_r.sys <= 1'b1;
         mem_r.word <= mode_r[ch_r][irq_pkg::MODE_WORD_BIT];
         if (st_r == ST_IDLE && ack_take && hit)
         begin
            mem_r.req <= 1'b1;
            mem_r.write <= 1'b0;
            mem_r.word <= mode_r[hit_chan][irq_pkg::MODE_WORD_BIT];
            mem_r.addr <= src_r[hit_chan][irq_pkg::ADDR_OUT_W-1:0];
         end
         else if (st_r == ST_READ && mem_ack)
         begin
            data_r <= mem_rdata;
            mem_r.write <= 1'b1;
            mem_r.addr <= dst_r[ch_r][irq_pkg::ADDR_OUT_W-1:0];
            mem_r.wdata <= mode_r[ch_r][irq_pkg::MODE_WORD_BIT] ? mem_rdata
                                                              : {8'h00, mem_rdata[7:0]};
         end
         else if (st_r == ST_WRITE && mem_ack)
         begin
            mem_r.req <= 1'b0;
            mem_r.write <= 1'b0;
         end
      end
   end

   // End of service; a zero count hands the source to general processing
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         done_r <= '0;
      end
      else
      begin
         done_r.valid <= (st_r == ST_FINISH);
         if (st_r == ST_FINISH)
         begin
            done_r.general <= (cnt_dec == 16'h0000);
            done_r.chan <= ch_r;
         end
      end
   end

   // Parameters; the engine's own update wins over a bus write in the same cycle.
   // Undefined operation codes behave as fixed but are not meant to be used.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         src_r <= {irq_pkg::NUM_DMA{irq_pkg::RST_ADDR}};
         dst_r <= {irq_pkg::NUM_DMA{irq_pkg::RST_ADDR}};
         mode_r <= {irq_pkg::NUM_DMA{irq_pkg::RST_MODE}};
         cnt_r <= {irq_pkg::NUM_DMA{irq_pkg::RST_COUNT}};
      end
      else if (st_r == ST_FINISH)
      begin
         src_r[ch_r] <= irq_pkg::next_addr(src_r[ch_r],
            mode_r[ch_r][irq_pkg::MODE_SRC_LSB +: 2],
            mode_r[ch_r][irq_pkg::MODE_WORD_BIT]);
         dst_r[ch_r] <= irq_pkg::next_addr(dst_r[ch_r],
            mode_r[ch_r][irq_pkg::MODE_DST_LSB +: 2],
            mode_r[ch_r][irq_pkg::MODE_WORD_BIT]);
         cnt_r[ch_r] <= cnt_dec;
      end
      else if (wr_en && is_param)
      begin
         unique case (a_idx_r[3:2])
            irq_pkg::GRP_SRC: src_r[a_idx_r[1:0]] <= hwdata;
            irq_pkg::GRP_DST: dst_r[a_idx_r[1:0]] <= hwdata;
            irq_pkg::GRP_MODE: mode_r[a_idx_r[1:0]] <= hwdata[4:0];
            irq_pkg::GRP_CNT: cnt_r[a_idx_r[1:0]] <= hwdata[15:0];
         endcase
      end
   end

endmodule : irq_ctrl_top

// [core/irq_pkg.sv]
// Shared constants, types and helpers of the interrupt controller with micro-DMA
package irq_pkg;

   localparam int NUM_CH = 20;
   localparam int NUM_NMI = 2;
   localparam int NUM_SRC = 22;
   localparam int NUM_DMA = 4;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] IDX_PRIO_FIRST = 8'h70;
   localparam logic [7:0] IDX_PRIO_COUNT = 8'h0a;
   localparam logic [7:0] IDX_SVEC_FIRST = 8'h7c;
   localparam logic [7:0] IDX_PARAM_FIRST = 8'h80;
   localparam logic [1:0] GRP_SRC = 2'h0;
   localparam logic [1:0] GRP_DST = 2'h1;
   localparam logic [1:0] GRP_MODE = 2'h2;
   localparam logic [1:0] GRP_CNT = 2'h3;
   localparam int ADDR_IDX_LSB = 2;
   localparam int ADDR_IDX_MSB = 9;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam int HPROT_PRIV_BIT = 1;

   // Priority register fields, two channels per register
   localparam int PRIO_LVL_LSB = 0;
   localparam int PRIO_CLR_BIT = 3;
   localparam int PRIO_HALF_W = 4;

   // Transfer mode fields
   localparam int MODE_WORD_BIT = 0;
   localparam int MODE_DST_LSB = 1;
   localparam int MODE_SRC_LSB = 3;
   localparam logic [1:0] OP_FIXED = 2'h0;
   localparam logic [1:0] OP_INC = 2'h1;
   localparam logic [1:0] OP_DEC = 2'h2;

   localparam logic [2:0] LEVEL_OFF_LO = 3'h0;
   localparam logic [2:0] LEVEL_NMI = 3'h7;
   localparam int ADDR_OUT_W = 24;

   // Reset values
   localparam logic [2:0] RST_LEVEL = 3'h0;
   localparam logic [4:0] RST_SVEC = 5'h00;
   localparam logic [31:0] RST_ADDR = 32'h0000_0000;
   localparam logic [4:0] RST_MODE = 5'h00;
   localparam logic [15:0] RST_COUNT = 16'h0000;

   // Vector bits 8..4 of each source, ascending so a lower index is a smaller vector
   localparam logic [4:0] SRC_VEC [NUM_SRC] = '{
      5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12,
      5'h13, 5'h14, 5'h15, 5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1c, 5'h1d, 5'h1e, 5'h1f};

   typedef struct packed {
      logic valid;
      logic [2:0] level;
      logic [15:0] vector;
   } irq_req_s;

   typedef struct packed {
      logic valid;
      logic dma;
      logic [1:0] chan;
      logic [15:0] vector;
   } irq_ack_s;

   typedef struct packed {
      logic valid;
      logic general;
      logic [1:0] chan;
   } dma_done_s;

   typedef struct packed {
      logic req;
      logic write;
      logic word;
      logic sys;
      logic [ADDR_OUT_W-1:0] addr;
      logic [15:0] wdata;
   } mem_req_s;

   function automatic logic [31:0] next_addr(input logic [31:0] a, input logic [1:0] op,
                                             input logic word);
      logic [31:0] step;
      step = word ? 32'h0000_0002 : 32'h0000_0001;
      unique case (op)
         OP_INC: next_addr = a + step;
         OP_DEC: next_addr = a - step;
         default: next_addr = a;
      endcase
   endfunction : next_addr

endpackage : irq_pkg

// [core/pend_arbiter.sv]
// Priority selection among pending interrupt sources
module pend_arbiter (
   input wire logic [irq_pkg::NUM_SRC-1:0] pend,
   input wire logic [irq_pkg::NUM_SRC-1:0][2:0] lvl,
   output logic win_valid,
   output logic [4:0] win_idx,
   output logic [2:0] win_level
);
   always_comb
   begin
      logic [2:0] eff;
      logic ok;
      eff = irq_pkg::LEVEL_OFF_LO;
      ok = 1'b0;
      win_valid = 1'b0;
      win_idx = 5'h00;
      win_level = irq_pkg::LEVEL_OFF_LO;
      // Descending scan with >= lets the smaller vector win a tie
      for (int i = irq_pkg::NUM_SRC - 1; i >= 0; i--)
      begin
         eff = (i < irq_pkg::NUM_NMI) ? irq_pkg::LEVEL_NMI : lvl[i];
         ok = pend[i] && ((i < irq_pkg::NUM_NMI) ||
              (lvl[i] != irq_pkg::LEVEL_OFF_LO && lvl[i] != irq_pkg::LEVEL_NMI));
         if (ok && (!win_valid || eff >= win_level))
         begin
            win_valid = 1'b1;
            win_idx = 5'(i);
            win_level = eff;
         end
      end
   end
endmodule : pend_arbiter

// [core/vec_match.sv]
// Compares an accepted vector against the four micro-DMA start vectors
module vec_match (
   input wire logic [4:0] field,
   input wire logic [irq_pkg::NUM_DMA-1:0][4:0] svec,
   output logic hit,
   output logic [1:0] chan
);
   always_comb
   begin
      hit = 1'b0;
      chan = 2'h0;
      for (int n = irq_pkg::NUM_DMA - 1; n >= 0; n--)
      begin
         if (svec[n] == field)
         begin
            hit = 1'b1;
            chan = 2'(n);
         end
      end
   end
endmodule : vec_match

// [tb/irq_ctrl_checker.sv]
// Port assertions for the interrupt controller with micro-DMA
module irq_ctrl_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic vec_read,
   input wire logic mem_ack,
   input wire logic dma_busy,
   input wire irq_pkg::irq_req_s irq_out,
   input wire irq_pkg::irq_ack_s ack_out,
   input wire irq_pkg::dma_done_s done_out,
   input wire irq_pkg::mem_req_s mem_out
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_read_wait: assert property (
      hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_ack_after_read: assert property (
      vec_read && irq_out.valid && !dma_busy
      |=> ack_out.valid && ack_out.vector == $past(irq_out.vector))
      else $error("acceptance not answered with presented vector");
   a_level_legal: assert property (
      irq_out.valid |-> irq_out.level != 3'h0)
      else $error("request presented at level zero");
   a_vector_shape: assert property (
      irq_out.valid |-> irq_out.vector[15:9] == 7'h00 && irq_out.vector[3:0] == 4'h0)
      else $error("vector outside bits 8 to 4");
   a_dma_sys_space: assert property (
      mem_out.req |-> mem_out.sys && dma_busy)
      else $error("transfer not in system space");
   a_byte_upper: assert property (
      mem_out.req && mem_out.write && !mem_out.word |-> mem_out.wdata[15:8] == 8'h00)
      else $error("byte write carries upper data");
   a_req_holds: assert property (
      mem_out.req && !mem_ack |=> mem_out.req && $stable(mem_out.addr) && $stable(mem_out.write))
      else $error("memory request dropped before ack");
   a_done_pulse: assert property (
      done_out.valid |=> !done_out.valid)
      else $error("done longer than one cycle");

   c_dma_ack: cover property (ack_out.valid && ack_out.dma);
   c_done_general: cover property (done_out.valid && done_out.general);
   c_done_quiet: cover property (done_out.valid && !done_out.general);
endmodule : irq_ctrl_checker

bind irq_ctrl_top irq_ctrl_checker irq_ctrl_checker_i (.hclk, .hresetn, .hsel, .htrans,
   .hwrite, .hready, .hreadyout, .vec_read, .mem_ack, .dma_busy, .irq_out, .ack_out,
   .done_out, .mem_out);

// [tb/irq_ctrl_top_tb.sv]
// Self-checking bench for the interrupt controller with micro-DMA
module irq_ctrl_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hwrite, vec_read, wdt_req, nmi_pin, mem_ack;
   logic hreadyout, hresp, dma_busy;
   logic [31:0] haddr, hwdata, hrdata, rd_v;
   logic [1:0] htrans;
   logic [2:0] hsize, mask;
   logic [3:0] hprot, lat;
   logic [19:0] periph_req;
   logic [15:0] mem_rdata;
   irq_pkg::irq_req_s irq_out;
   irq_pkg::irq_ack_s ack_out;
   irq_pkg::dma_done_s done_out;
   irq_pkg::mem_req_s mem_out;
   int failures = 0;
   int tests_run = 0;
   int cyc = 0;
   localparam logic [15:0] ev [5] = '{16'h0080, 16'h0090, 16'h00c0, 16'h00a0, 16'h00b0};
   localparam logic [4:0] bmode [2] = '{5'h0c, 5'h00};

   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   irq_ctrl_top irq_ctrl_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hprot, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .periph_req,
      .wdt_req, .nmi_pin, .vec_read, .irq_out, .ack_out, .done_out, .mem_out, .mem_ack,
      .mem_rdata, .dma_busy);
   mem_model mem_model_i (.hclk, .req(mem_out), .lat, .ack(mem_ack), .rdata(mem_rdata));

   task finish_test();
      $display("comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Single AHB word transfer; read data lands in rd_v
   task bus(input logic [7:0] idx, input logic wr, input logic [31:0] d, input logic p);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= wr;
      hprot <= {2'h0, p, 1'b1};
      do @(posedge hclk); while (!hreadyout);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (!hreadyout);
      rd_v = hrdata;
   endtask : bus

   task pulse(input logic [19:0] r);
      @(posedge hclk);
      periph_req <= r;
      @(posedge hclk);
      periph_req <= 20'h0;
      repeat (3) @(posedge hclk);
   endtask : pulse

   // CPU side: take the request only above the mask, restore the mask on return
   task accept();
      logic [2:0] saved;
      saved = mask;
      if (irq_out.valid && irq_out.level > mask)
      begin
         vec_read <= 1'b1;
         mask = (irq_out.level == 3'h7) ? 3'h7 : irq_out.level + 3'h1;
         @(posedge hclk);
         vec_read <= 1'b0;
         @(posedge hclk);
      end
      mask = saved;
   endtask : accept

   task dma_run(input logic [19:0] r, input logic gen);
      pulse(r);
      accept();
      chk({ack_out.dma, ack_out.chan}, 3'h4);
      while (done_out.valid !== 1'b1)
         @(posedge hclk);
      chk({done_out.general, done_out.chan}, {gen, 2'h0});
   endtask : dma_run

   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         failures++;
         finish_test();
      end
   end

   initial
   begin
      {hresetn, hsel, haddr, htrans, hwrite, hprot, hwdata} = '0;
      {periph_req, wdt_req, nmi_pin, vec_read, lat, mask} = '0;
      hsize = 3'h2;
      mem_model_i.m[10'h010] = 8'h34;
      mem_model_i.m[10'h011] = 8'h12;
      mem_model_i.m[10'h00e] = 8'h78;
      mem_model_i.m[10'h00f] = 8'h56;
      mem_model_i.m[10'h00a] = 8'h9a;
      mem_model_i.m[10'h00b] = 8'hbc;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      bus(8'h70, 1'b0, 32'h0, 1'b1);
      chk(rd_v, 32'h0);
      bus(8'h20, 1'b0, 32'h0, 1'b1);
      chk(rd_v, 32'h0);
      chk(hresp, 1'b0);
      bus(8'h8c, 1'b1, 32'h5, 1'b0);
      bus(8'h8c, 1'b0, 32'h0, 1'b1);
      chk(rd_v, 32'h0);
      $display("test registers done");
      for (int l = 0; l < 8; l++)
      begin
         bus(8'h72, 1'b1, {28'h0, 1'b1, l[2:0]}, 1'b0);
         pulse(20'h10);
         if (l inside {[1:6]})
            chk(irq_out, {1'b1, l[2:0], 16'h00e0});
         else
            chk(irq_out.valid, 1'b0);
         bus(8'h72, 1'b0, 32'h0, 1'b0);
         chk(rd_v[3], 1'b1);
         bus(8'h72, 1'b1, {28'h0, 1'b0, l[2:0]}, 1'b0);
         bus(8'h72, 1'b0, 32'h0, 1'b0);
         chk(rd_v[3:0], {1'b0, l[2:0]});
      end
      $display("test levels done");
      bus(8'h70, 1'b1, 32'hbb, 1'b0);
      bus(8'h71, 1'b1, 32'h8d, 1'b0);
      pulse(20'h3);
      chk(irq_out, {1'b1, 3'h3, 16'h00a0});
      pulse(20'h4);
      chk(irq_out, {1'b1, 3'h5, 16'h00c0});
      wdt_req <= 1'b1;
      pulse(20'h0);
      wdt_req <= 1'b0;
      chk(irq_out, {1'b1, 3'h7, 16'h0090});
      nmi_pin <= 1'b1;
      repeat (6) @(posedge hclk);
      chk(irq_out, {1'b1, 3'h7, 16'h0080});
      foreach (ev[i])
      begin
         accept();
         chk({ack_out.valid, ack_out.dma, ack_out.vector}, {2'b10, ev[i]});
      end
      chk(irq_out.valid, 1'b0);
      $display("test arbitration done");
      bus(8'h80, 1'b1, 32'h1234_5010, 1'b1);
      bus(8'h84, 1'b1, 32'h0000_0100, 1'b1);
      bus(8'h88, 1'b1, 32'h13, 1'b1);
      bus(8'h8c, 1'b1, 32'h2, 1'b1);
      bus(8'h73, 1'b1, 32'ha, 1'b0);
      bus(8'h7c, 1'b1, 32'h10, 1'b0);
      bus(8'h7d, 1'b1, 32'h10, 1'b0);
      lat <= 4'h3;
      dma_run(20'h40, 1'b0);
      chk({mem_model_i.m[10'h101], mem_model_i.m[10'h100]}, 16'h1234);
      chk(irq_out.valid, 1'b0);
      bus(8'h80, 1'b0, 32'h0, 1'b1);
      chk(rd_v, 32'h1234_500e);
      bus(8'h84, 1'b0, 32'h0, 1'b1);
      chk(rd_v, 32'h0000_0102);
      bus(8'h8c, 1'b0, 32'h0, 1'b1);
      chk(rd_v, 32'h1);
      lat <= 4'h0;
      dma_run(20'h40, 1'b1);
      chk({mem_model_i.m[10'h103], mem_model_i.m[10'h102]}, 16'h5678);
      dma_run(20'h40, 1'b0);
      bus(8'h8c, 1'b0, 32'h0, 1'b1);
      chk(rd_v, 32'hffff);
      for (int j = 0; j < 2; j++)
      begin
         bus(8'h88, 1'b1, {27'h0, bmode[j]}, 1'b1);
         dma_run(20'h40, 1'b0);
         chk(mem_model_i.m[10'h106 - j[9:0]], j ? 8'hbc : 8'h9a);
         bus(8'h80, 1'b0, 32'h0, 1'b1);
         chk(rd_v, 32'h1234_500b);
         bus(8'h84, 1'b0, 32'h0, 1'b1);
         chk(rd_v, 32'h0000_0105);
      end
      $display("test micro-dma done");
      finish_test();
   end
endmodule : irq_ctrl_top_tb

// [tb/mem_model.sv]
// Memory partner answering micro-DMA requests after a set delay
module mem_model (
   input wire logic hclk,
   input wire irq_pkg::mem_req_s req,
   input wire logic [3:0] lat,
   output logic ack,
   output logic [15:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] m [1024];
   logic [3:0] cnt = 4'h0;
   logic ack_r = 1'b0;
   logic [15:0] rdata_r = 16'h0000;

   assign ack = ack_r;
   assign rdata = rdata_r;

   // Read data toggles outside the ack cycle so stale values never look valid
   always @(posedge hclk)
   begin
      ack_r <= 1'b0;
      rdata_r <= ~rdata_r;
      if (req.req && !ack_r)
      begin
         if (cnt != lat)
            cnt <= cnt + 4'h1;
         else
         begin
            cnt <= 4'h0;
            ack_r <= 1'b1;
            rdata_r <= {m[req.addr[9:0] + 10'h1], m[req.addr[9:0]]};
            if (req.write)
               m[req.addr[9:0]] <= req.wdata[7:0];
            if (req.write && req.word)
               m[req.addr[9:0] + 10'h1] <= req.wdata[15:8];
         end
      end
   end
endmodule : mem_model
